// [dv/wrw_top_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module wrw_top_bench;
  logic ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, halt_request = 0;
  logic hw_watchdog_option = 0, halt_reset_option = 1, he;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [1:0] timebase_select = 2'h0;
  logic avs_waitrequest, halt_enter, wdg_reset_n, watchdog_active;
  int n_fail = 0, checks_done = 0, cyc = 0, n;
  wrw_top i_wrw_top (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .timebase_select, .hw_watchdog_option, .halt_reset_option, .halt_request,
    .halt_enter, .wdg_reset_n, .watchdog_active);
  // ==========
  // Clock, hang guard, helpers
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      complete_run();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until the edge that sees waitrequest low; only the
  // hang guard ends a wait that never gets an answer
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wl(input logic v, input int lim);
    n = 0;
    while (wdg_reset_n !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task rst();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask
  task halt();
    @(posedge ref_clk);
    halt_request <= 1'b1;
    @(posedge ref_clk);
    halt_request <= 1'b0;
    @(negedge ref_clk);
    he = halt_enter;
    wl(0, 4);
  endtask
  task complete_run();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========
  // Scenarios
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus(0, 4'h0, 0); chk(q, 32'h7f);
    bus(0, 4'h3, 0); chk(q, 32'h0);
    halt(); chk(he, 1'b1);
    repeat (16400) @(posedge ref_clk);
    bus(0, 4'h0, 0); chk(q, 32'h7e);
    $display("free count done");
    bus(1, 4'h0, 32'hc1);
    bus(1, 4'h0, 32'h7f);
    bus(0, 4'h0, 0); chk(q, 32'hff);
    chk(watchdog_active, 1'b1);
    bus(1, 4'h0, 32'hc1); wl(0, 40000);
    chk(32'(n > 16000 && n < 32800), 32'h1);
    wl(1, 2000); chk(n, 32'd1200);
    $display("rollover done");
    rst(); timebase_select <= 2'h1;
    bus(0, 4'h0, 0); chk(q, 32'h7f);
    chk(watchdog_active, 1'b0);
    // Reloaded upper stage brings the first tick well before 16384
    repeat (13000) @(posedge ref_clk);
    bus(0, 4'h0, 0); chk(q, 32'h7e);
    $display("timebase phase done");
    bus(1, 4'h0, 32'h80); wl(0, 10); chk(32'(n < 4), 32'h1);
    wl(1, 2000); halt(); chk(32'(n < 2), 32'h1);
    chk(he, 1'b0);
    wl(1, 2000); rst(); hw_watchdog_option <= 1'b1;
    bus(0, 4'h0, 0); chk(q[7], 1'b1);
    halt(); chk(32'(n < 2), 32'h1);
    $display("forced resets done");
    complete_run();
  end
endmodule
`default_nettype wire

// [dv/wrw_top_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checks
module wrw_top_monitor (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        hw_watchdog_option,
  input wire logic        halt_reset_option,
  input wire logic        halt_request,
  input wire logic        halt_enter,
  input wire logic        wdg_reset_n,
  input wire logic        watchdog_active
);
  logic [10:0] low_cnt;
  logic        wr0;
  assign wr0 = avs_write && !avs_waitrequest && avs_address == 4'h0
               && avs_byteenable[0];
  // Counts the low cycles of the pulse
  always_ff @(posedge ref_clk) begin
    low_cnt <= wdg_reset_n ? 11'h0 : low_cnt + 11'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_pulse_len: assert property ($rose(wdg_reset_n)
    |-> low_cnt == 11'h4b0) else $error("reset pulse length wrong");
  a_force_rst: assert property (wr0 && avs_writedata[7:6] == 2'h2
    && wdg_reset_n |-> ##[1:3] !wdg_reset_n) else $error("no forced reset");
  a_act_set: assert property (wr0 && avs_writedata[7]
    |=> ##[0:1] watchdog_active) else $error("activate not set");
  a_act_sticky: assert property (watchdog_active |=> watchdog_active)
    else $error("activate cleared");
  a_rst_clear: assert property ($fell(sys_rst) |-> !watchdog_active)
    else $error("active after reset");
  a_halt_rst: assert property (halt_request && halt_reset_option
    && (watchdog_active || hw_watchdog_option) && wdg_reset_n
    |=> !wdg_reset_n) else $error("halt gave no reset");
  a_halt_pass: assert property (halt_request && !watchdog_active
    && !hw_watchdog_option |=> halt_enter) else $error("halt not entered");
  a_unmap_zero: assert property (avs_read && !avs_waitrequest
    && avs_address != 4'h0 |-> avs_readdata == 32'h0)
    else $error("unmapped read nonzero");
  c_pulse: cover property ($fell(wdg_reset_n));
  c_halt: cover property (halt_enter);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind wrw_top wrw_top_monitor i_wrw_top_monitor (.ref_clk, .sys_rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .hw_watchdog_option, .halt_reset_option,
  .halt_request, .halt_enter, .wdg_reset_n, .watchdog_active);
`default_nettype wire

// [hdl/wrw_consts.svh]
`ifndef WRW_CONSTS_SVH
`define WRW_CONSTS_SVH

// ==========================================================================
// Register map
`define WRW_CTRL_OFS        4'h0
`define WRW_ACT_BIT         7
`define WRW_TOP_BIT         6
`define WRW_CTRL_RESET      8'h7f
`define WRW_CNT_ROLL_FROM   7'h40

// ==========================================================================
// Prescaler: 64 oscillator cycles per low stage, 256 low stages per tick
`define WRW_OSC_PER_TICK    16384
`define WRW_PRE_LO_LAST     6'h3f
`define WRW_PRE_HI_LAST     8'hff
`define WRW_PHASE_TB0       8'h3b
`define WRW_PHASE_TB1       8'h35
`define WRW_PHASE_TB2       8'h23
`define WRW_PHASE_TB3       8'h36

// ==========================================================================
// Reset pulse timing
`define WRW_CLK_PERIOD_NS   25
`define WRW_RST_PULSE_NS    30000
`define WRW_RST_CYCLES      (`WRW_RST_PULSE_NS / `WRW_CLK_PERIOD_NS)

`endif

// [hdl/wrw_pkg.sv]
package wrw_pkg;

  // ========================================================================
  // Whole state of the watchdog, registered in one place
  typedef struct packed {
    logic [5:0]  pre_lo;
    logic [7:0]  pre_hi;
    logic [1:0]  tb_last;
    logic        activate;
    logic [6:0]  count;
    logic [10:0] rst_cnt;
    logic        rst_n;
    logic        wait_n;
    logic [31:0] rdata;
    logic        halt_go;
  } wrw_state_t;

endpackage

// [hdl/wrw_top.sv]
// What this block does
// - Count down once per 16384 oscillator cycles
// - Counter runs even while watchdog disabled
// - Active and 40h to 3Fh roll: reset
// - Reset pin held low about 30 microseconds
// - Six low bits set 64 timeout steps
// - After reset the watchdog is inactive unless the option strap is set
// - Once active, only reset deactivates it
// - Write activate with top bit clear: reset
// - Halt while active resets, option gated
// - Option strap makes watchdog always active
// - Counter writes leave shared prescaler untouched
// - Prescaler phase follows timebase select field
// - Activate bit set-only by software writes
// - Hardware option overrides the activate bit
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "wrw_consts.svh"

module wrw_top (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic [1:0]  timebase_select,
  input  wire logic        hw_watchdog_option,
  input  wire logic        halt_reset_option,
  input  wire logic        halt_request,
  output var  logic        halt_enter,
  output var  logic        wdg_reset_n,
  output var  logic        watchdog_active
);

  // ========================================================================
  // State
  wrw_pkg::wrw_state_t state_reg;
  wrw_pkg::wrw_state_t state_next;

  logic       hit;
  logic       wr_hit;
  logic       tick;
  logic       active;
  logic       active_after;
  logic       fire;
  logic [7:0] phase;

  // ========================================================================
  // Decode and prescaler taps
  always_comb begin
    hit    = (avs_address == `WRW_CTRL_OFS);
    // Write lands on the edge that answers it, not when it is first seen
    wr_hit = avs_write && state_reg.wait_n && hit && avs_byteenable[0];
    tick   = (state_reg.pre_lo == `WRW_PRE_LO_LAST) &&
             (state_reg.pre_hi == `WRW_PRE_HI_LAST);
    active = state_reg.activate || hw_watchdog_option;
    unique case (timebase_select)
      2'h0: phase = `WRW_PHASE_TB0;
      2'h1: phase = `WRW_PHASE_TB1;
      2'h2: phase = `WRW_PHASE_TB2;
      2'h3: phase = `WRW_PHASE_TB3;
    endcase
  end

  // ========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    fire       = 1'b0;

    // Prescaler is shared timebase logic; bus writes never touch it
    state_next.pre_lo  = state_reg.pre_lo + 6'h01;
    state_next.tb_last = timebase_select;
    if (state_reg.pre_lo == `WRW_PRE_LO_LAST) begin
      state_next.pre_hi = state_reg.pre_hi + 8'h01;
    end
    // Timebase change reloads the upper stage, shifting the tick phase
    if (timebase_select != state_reg.tb_last) begin
      state_next.pre_hi = phase;
    end

    // Free-running count regardless of activation
    if (tick) begin
      state_next.count = state_reg.count - 7'h01;
      if (active && state_reg.count == `WRW_CNT_ROLL_FROM) begin
        fire = 1'b1;
      end
    end

    // Register write: activate only ever sets, counter loads
    active_after = active;
    if (wr_hit) begin
      state_next.count = avs_writedata[`WRW_TOP_BIT:0];
      if (avs_writedata[`WRW_ACT_BIT]) begin
        state_next.activate = 1'b1;
      end
      active_after = active || avs_writedata[`WRW_ACT_BIT];
      if (active_after && !avs_writedata[`WRW_TOP_BIT]) begin
        fire = 1'b1;
      end
    end

    // Halt while active becomes a reset when the option allows it
    state_next.halt_go = 1'b0;
    if (halt_request) begin
      if (active && halt_reset_option) begin
        fire = 1'b1;
      end else begin
        state_next.halt_go = 1'b1;
      end
    end

    // Reset pulse; a second trigger during the pulse is absorbed
    if (state_reg.rst_cnt != 11'h000) begin
      state_next.rst_cnt = state_reg.rst_cnt - 11'h001;
      state_next.rst_n   = (state_reg.rst_cnt == 11'h001);
    end else if (fire) begin
      state_next.rst_cnt = 11'(`WRW_RST_CYCLES);
      state_next.rst_n   = 1'b0;
    end

    // Avalon slave: one wait cycle, answer on the following edge
    state_next.wait_n = 1'b0;
    if ((avs_read || avs_write) && !state_reg.wait_n) begin
      state_next.wait_n = 1'b1;
      state_next.rdata  = 32'h0000_0000;
      if (avs_read && hit) begin
        state_next.rdata[7:0] = {active, state_reg.count};
      end
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg          <= '0;
      state_reg.activate <= 1'b0;
      state_reg.count    <= 7'(`WRW_CTRL_RESET);
      state_reg.rst_n    <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Outputs, all straight from state flops
  always_comb begin
    avs_readdata    = state_reg.rdata;
    avs_waitrequest = !state_reg.wait_n;
    halt_enter      = state_reg.halt_go;
    wdg_reset_n     = state_reg.rst_n;
    watchdog_active = state_reg.activate;
  end

endmodule
`default_nettype wire
